// *** rtl/pwmc_top.v ***
`timescale 1ns/10ps
`include "pwmc_regs.vh"

module pwmc_top
#(
    parameter NUM_CH = 3,
    parameter CNT_W = 16,
    parameter SEL_W = 3,
    parameter DIV_W = 7
)
(
    input wire core_clk,
    input wire rst_n,
    input wire [7:0] regAddr,
    input wire [31:0] regWrData,
    input wire regWrEn,
    input wire regRdEn,
    output wire [31:0] regRdData,
    output wire [NUM_CH-1:0] pwmOut
);

    reg [31:0] rdData_ff;
    reg [31:0] nxt_rdData;
    wire [32*NUM_CH-1:0] ctrlView;
    wire [32*NUM_CH-1:0] setView;
    wire [NUM_CH-1:0] pendView;
    wire [NUM_CH-1:0] outView;
    wire [NUM_CH-1:0] ctrlHit;
    wire [NUM_CH-1:0] setHit;
    wire [31:0] statView;
    integer k;

    assign regRdData = rdData_ff;
    assign pwmOut = outView;
    assign statView = {16'h0000, {(8-NUM_CH){1'b0}}, pendView, {(8-NUM_CH){1'b0}}, outView};

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch = ch + 1)
        begin : g_ch
            // Register addresses step by the channel stride from channel 3.
            wire [7:0] ctrlAddr;
            wire [7:0] setAddr;
            wire [31:0] ctrlAddrFull;
            wire [31:0] setAddrFull;
            assign ctrlAddrFull = `PWMC_CH3_CONTROL + ch * `PWMC_CH_STRIDE;
            assign setAddrFull = `PWMC_CH3_COUNT_SETTINGS + ch * `PWMC_CH_STRIDE;
            assign ctrlAddr = ctrlAddrFull[7:0];
            assign setAddr = setAddrFull[7:0];
            assign ctrlHit[ch] = (regAddr == ctrlAddr);
            assign setHit[ch] = (regAddr == setAddr);

            wire ctrlWr;
            wire setWr;
            assign ctrlWr = regWrEn & (regAddr == ctrlAddr);
            assign setWr = regWrEn & (regAddr == setAddr);

            // Software-visible fields.
            reg run_ff;
            reg secondEdge_ff;
            reg countDir_ff;
            reg [SEL_W-1:0] prescale_ff;
            reg deferred_ff;
            reg [CNT_W-1:0] match_ff;
            reg [CNT_W-1:0] limit_ff;

            // Working settings that the counter really uses.
            reg wEdge_ff;
            reg wDir_ff;
            reg [SEL_W-1:0] wPrescale_ff;
            reg [CNT_W-1:0] wMatch_ff;
            reg [CNT_W-1:0] wLimit_ff;

            reg [CNT_W-1:0] cnt_ff;
            reg down_ff;
            reg out_ff;
            reg [CNT_W-1:0] nxt_cnt;
            reg nxt_down;
            reg boundary;
            wire tick;
            wire immediate;
            wire doLoad;
            wire cmpHigh;
            wire nxt_out;

            pwmc_prescaler
            #(
                .SEL_W(SEL_W),
                .DIV_W(DIV_W)
            )
            u_presc
            (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .run(run_ff),
                .prescaleSel(wPrescale_ff),
                .countTick(tick)
            );

            // Counter step and period boundary.
            always @*
            begin
                nxt_cnt = cnt_ff;
                nxt_down = down_ff;
                boundary = 1'b0;
                if (!run_ff)
                begin
                    nxt_cnt = {CNT_W{1'b0}};
                    nxt_down = 1'b0;
                end
                else if (tick)
                begin
                    if (!wDir_ff)
                    begin
                        if (cnt_ff >= wLimit_ff)
                        begin
                            nxt_cnt = {CNT_W{1'b0}};
                            boundary = 1'b1;
                        end
                        else
                        begin
                            nxt_cnt = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
                        end
                        nxt_down = 1'b0;
                    end
                    else if (!down_ff)
                    begin
                        if (cnt_ff >= wLimit_ff)
                        begin
                            nxt_down = (wLimit_ff != {CNT_W{1'b0}});
                            nxt_cnt = (wLimit_ff == {CNT_W{1'b0}}) ? cnt_ff :
                                cnt_ff - {{(CNT_W-1){1'b0}}, 1'b1};
                            boundary = (wLimit_ff == {CNT_W{1'b0}});
                        end
                        else
                        begin
                            nxt_cnt = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
                        end
                    end
                    else
                    begin
                        if (cnt_ff == {CNT_W{1'b0}})
                        begin
                            nxt_down = 1'b0;
                            nxt_cnt = {{(CNT_W-1){1'b0}}, 1'b1};
                            boundary = 1'b1;
                        end
                        else
                        begin
                            nxt_cnt = cnt_ff - {{(CNT_W-1){1'b0}}, 1'b1};
                        end
                    end
                end
            end

            assign immediate = ctrlWr & regWrData[`PWMC_IMMEDIATE_BIT];
            // A stopped channel has no boundary to wait for, so a request loads at once.
            assign doLoad = immediate | (deferred_ff & (boundary | ~run_ff));

            // Up mode: second edge at match; up-down: second edge at match going down.
            assign cmpHigh = wDir_ff ? (nxt_cnt < wMatch_ff) : (nxt_cnt >= wMatch_ff);
            assign nxt_out = run_ff & (cmpHigh ^ wEdge_ff);

            always @(posedge core_clk)
            begin
                if (!rst_n)
                begin
                    run_ff <= 1'b0;
                    secondEdge_ff <= 1'b0;
                    countDir_ff <= 1'b0;
                    prescale_ff <= {SEL_W{1'b0}};
                    deferred_ff <= 1'b0;
                    match_ff <= {CNT_W{1'b0}};
                    limit_ff <= {CNT_W{1'b0}};
                end
                else
                begin
                    if (ctrlWr)
                    begin
                        run_ff <= regWrData[`PWMC_RUN_BIT];
                        secondEdge_ff <= regWrData[`PWMC_SECOND_EDGE_BIT];
                        countDir_ff <= regWrData[`PWMC_COUNT_DIR_BIT];
                        prescale_ff <= regWrData[`PWMC_PRESCALE_MSB:`PWMC_PRESCALE_LSB];
                    end
                    // A new request in the same cycle as the self-clear wins.
                    if (ctrlWr & regWrData[`PWMC_DEFERRED_BIT])
                    begin
                        deferred_ff <= 1'b1;
                    end
                    else if (doLoad)
                    begin
                        deferred_ff <= 1'b0;
                    end
                    if (setWr)
                    begin
                        match_ff <= regWrData[`PWMC_MATCH_MSB:`PWMC_MATCH_LSB];
                        limit_ff <= regWrData[`PWMC_LIMIT_MSB:`PWMC_LIMIT_LSB];
                    end
                end
            end

            // Control transfer sources take this cycle's write so an immediate load sees new control fields.
            always @(posedge core_clk)
            begin
                if (!rst_n)
                begin
                    wEdge_ff <= 1'b0;
                    wDir_ff <= 1'b0;
                    wPrescale_ff <= {SEL_W{1'b0}};
                    wMatch_ff <= {CNT_W{1'b0}};
                    wLimit_ff <= {CNT_W{1'b0}};
                end
                else if (doLoad)
                begin
                    wEdge_ff <= ctrlWr ? regWrData[`PWMC_SECOND_EDGE_BIT] : secondEdge_ff;
                    wDir_ff <= ctrlWr ? regWrData[`PWMC_COUNT_DIR_BIT] : countDir_ff;
                    wPrescale_ff <= ctrlWr ?
                        regWrData[`PWMC_PRESCALE_MSB:`PWMC_PRESCALE_LSB] : prescale_ff;
                    wMatch_ff <= match_ff;
                    wLimit_ff <= limit_ff;
                end
            end

            always @(posedge core_clk)
            begin
                if (!rst_n)
                begin
                    cnt_ff <= {CNT_W{1'b0}};
                    down_ff <= 1'b0;
                    out_ff <= 1'b0;
                end
                else
                begin
                    cnt_ff <= nxt_cnt;
                    down_ff <= nxt_down;
                    out_ff <= nxt_out;
                end
            end

            // Immediate-load bit is a strobe and always reads back zero.
            assign ctrlView[32*ch+31:32*ch] = {1'b0, 14'h0000, deferred_ff, 1'b0,
                prescale_ff, 3'h0, countDir_ff, 3'h0, secondEdge_ff, 3'h0, run_ff};
            assign setView[32*ch+31:32*ch] = {match_ff, limit_ff};
            assign pendView[ch] = deferred_ff;
            assign outView[ch] = out_ff;
        end
    endgenerate

    // Read decode; unmapped addresses read as zero.
    always @*
    begin
        nxt_rdData = `PWMC_RDATA_RESET;
        if (regAddr == `PWMC_STATUS)
        begin
            nxt_rdData = statView;
        end
        else
        begin
            for (k = 0; k < NUM_CH; k = k + 1)
            begin
                if (ctrlHit[k])
                begin
                    nxt_rdData = ctrlView[32*k+:32];
                end
                else if (setHit[k])
                begin
                    nxt_rdData = setView[32*k+:32];
                end
            end
        end
    end

    // Read data stands only in the cycle after the strobe.
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            rdData_ff <= `PWMC_RDATA_RESET;
        end
        else if (regRdEn)
        begin
            rdData_ff <= nxt_rdData;
        end
        else
        begin
            rdData_ff <= `PWMC_RDATA_RESET;
        end
    end

endmodule // pwmc_top

// *** rtl/pwmc_regs.vh ***
`ifndef PWMC_REGS_VH
`define PWMC_REGS_VH

// Register byte addresses.
`define PWMC_CH3_CONTROL 8'h28
`define PWMC_CH3_COUNT_SETTINGS 8'h2C
`define PWMC_CH4_CONTROL 8'h34
`define PWMC_CH4_COUNT_SETTINGS 8'h38
`define PWMC_CH5_CONTROL 8'h40
`define PWMC_CH5_COUNT_SETTINGS 8'h44
`define PWMC_CH_STRIDE 8'h0C
`define PWMC_STATUS 8'h48

// Control word fields.
`define PWMC_RUN_BIT 0
`define PWMC_SECOND_EDGE_BIT 4
`define PWMC_COUNT_DIR_BIT 8
`define PWMC_PRESCALE_LSB 12
`define PWMC_PRESCALE_MSB 14
`define PWMC_DEFERRED_BIT 16
`define PWMC_IMMEDIATE_BIT 31

// Count-settings word fields.
`define PWMC_MATCH_LSB 16
`define PWMC_MATCH_MSB 31
`define PWMC_LIMIT_LSB 0
`define PWMC_LIMIT_MSB 15

// Status word fields.
`define PWMC_STAT_OUT_LSB 0
`define PWMC_STAT_PEND_LSB 8

// Reset values.
`define PWMC_CONTROL_RESET 32'h0000_0000
`define PWMC_SETTINGS_RESET 32'h0000_0000
`define PWMC_RDATA_RESET 32'h0000_0000

`endif

// *** rtl/pwmc_prescaler.v ***
`timescale 1ns/10ps
// Count-clock enable: one pulse every 2**sel core clocks while the channel runs.
module pwmc_prescaler
#(
    parameter SEL_W = 3,
    parameter DIV_W = 7
)
(
    input wire core_clk,
    input wire rst_n,
    input wire run,
    input wire [SEL_W-1:0] prescaleSel,
    output wire countTick
);

    reg [DIV_W-1:0] divCnt_ff;
    wire [DIV_W-1:0] nxt_divCnt;
    wire [DIV_W:0] maskWide;
    wire [DIV_W-1:0] divMask;

    // Mask of the low bits that must all be one; sel 0 gives mask 0, a tick every cycle.
    assign maskWide = ({{DIV_W{1'b0}}, 1'b1} << prescaleSel) - {{DIV_W{1'b0}}, 1'b1};
    assign divMask = maskWide[DIV_W-1:0];
    assign countTick = run & ((divCnt_ff & divMask) == divMask);
    assign nxt_divCnt = run ? divCnt_ff + {{(DIV_W-1){1'b0}}, 1'b1} : {DIV_W{1'b0}};

    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            divCnt_ff <= {DIV_W{1'b0}};
        end
        else
        begin
            divCnt_ff <= nxt_divCnt;
        end
    end

endmodule // pwmc_prescaler

// *** tb/pwmc_top_assertions.sv ***
`timescale 1ns/10ps
`include "pwmc_regs.vh"
module pwmc_top_checker
#(
    parameter NUM_CH = 3
)
(
    input wire core_clk,
    input wire rst_n,
    input wire [7:0] regAddr,
    input wire [31:0] regWrData,
    input wire regWrEn,
    input wire regRdEn,
    input wire [31:0] regRdData,
    input wire [NUM_CH-1:0] pwmOut
);
    reg [NUM_CH-1:0] runBits_ff;
    wire isCtrl = regAddr == `PWMC_CH3_CONTROL || regAddr == `PWMC_CH4_CONTROL
        || regAddr == `PWMC_CH5_CONTROL;
    wire isSet = regAddr == `PWMC_CH3_COUNT_SETTINGS || regAddr == `PWMC_CH4_COUNT_SETTINGS
        || regAddr == `PWMC_CH5_COUNT_SETTINGS;
    wire unmapped = !isCtrl && !isSet && regAddr != `PWMC_STATUS;
    // The run bits are shadowed from the bus so stopped channels can be checked.
    always @(posedge core_clk)
    begin
        if (!rst_n)
            runBits_ff <= {NUM_CH{1'b0}};
        else if (regWrEn && isCtrl)
            runBits_ff[(regAddr - `PWMC_CH3_CONTROL) / `PWMC_CH_STRIDE] <= regWrData[0];
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    property p_rd_idle;
        !$past(regRdEn) |-> regRdData == 32'h0000_0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_unmapped;
        regRdEn && unmapped |=> regRdData == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_ctrl_rsvd;
        regRdEn && isCtrl |=> (regRdData & 32'hFFFE_8EEE) == 32'h0000_0000;
    endproperty
    a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("control bits");
    property p_ctrl_rb;
        regWrEn && isCtrl ##1 !regWrEn ##1 regRdEn && regAddr == $past(regAddr, 2)
        |=> (regRdData & 32'h0000_7111) == ($past(regWrData, 3) & 32'h0000_7111);
    endproperty
    a_ctrl_rb: assert property (p_ctrl_rb) else $error("control readback");
    property p_set_rb;
        regWrEn && isSet ##1 !regWrEn ##1 regRdEn && regAddr == $past(regAddr, 2)
        |=> regRdData == $past(regWrData, 3);
    endproperty
    a_set_rb: assert property (p_set_rb) else $error("settings readback");
    property p_stopped;
        1'b1 |-> (pwmOut & ~runBits_ff & ~$past(runBits_ff)) == {NUM_CH{1'b0}};
    endproperty
    a_stopped: assert property (p_stopped) else $error("stopped output");
    property p_status;
        regRdEn && regAddr == `PWMC_STATUS |=> regRdData[NUM_CH-1:0] == $past(pwmOut);
    endproperty
    a_status: assert property (p_status) else $error("status output");
    property p_rst;
        $rose(rst_n) |-> pwmOut == {NUM_CH{1'b0}} && regRdData == 32'h0000_0000;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state");
endmodule // pwmc_top_checker

bind pwmc_top pwmc_top_checker #(.NUM_CH(NUM_CH)) u_chk (.core_clk(core_clk),
    .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData), .pwmOut(pwmOut));

// *** tb/pwmc_load_model.sv ***
`timescale 1ns/10ps
// Load on one output pin: measures period and high time in core clocks.
module pwmc_load_model
(
    input wire core_clk,
    input wire pin,
    output integer lastPeriod,
    output integer lastHigh
);
    reg prev_ff = 1'b0;
    integer sinceRise = 0;
    integer highRun = 0;
    initial lastPeriod = 0;
    initial lastHigh = 0;
    always @(posedge core_clk)
    begin
        prev_ff <= pin;
        sinceRise <= (pin && !prev_ff) ? 1 : sinceRise + 1;
        highRun <= (pin && !prev_ff) ? 1 : highRun + pin;
        if (pin && !prev_ff)
            lastPeriod <= sinceRise;
        if (!pin && prev_ff)
            lastHigh <= highRun;
    end
endmodule // pwmc_load_model

// *** tb/pwmc_tb.sv ***
`timescale 1ns/10ps
`include "pwmc_regs.vh"
module testbench;
    logic core_clk, rst_n, regWrEn, regRdEn;
    logic [7:0] regAddr;
    logic [31:0] regWrData, r, d;
    wire [31:0] regRdData;
    wire [2:0] pwmOut;
    logic [1:0] ch;
    integer lastPeriod, lastHigh, failures, n_compared, i, t, m, md, pl, p;
    pwmc_top dut (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regRdData(regRdData), .pwmOut(pwmOut));
    pwmc_load_model load (.core_clk(core_clk), .pin(pwmOut[ch]),
        .lastPeriod(lastPeriod), .lastHigh(lastHigh));
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    function [7:0] ca(input [1:0] c);
        ca = `PWMC_CH3_CONTROL + c * `PWMC_CH_STRIDE;
    endfunction
    function integer ePer(input integer t, md, p);
        ePer = (md ? 2 * t : t + 1) << p;
    endfunction
    function integer eHigh(input integer t, m, md, pl, p);
        eHigh = md ? 2 * m - 1 : t + 1 - m;
        eHigh = (pl ? ePer(t, md, 0) - eHigh : eHigh) << p;
    endfunction
    task wr(input [7:0] a, input [31:0] v);
        @(posedge core_clk);
        {regAddr, regWrData, regWrEn} <= {a, v, 1'b1};
        @(posedge core_clk);
        regWrEn <= 1'b0;
    endtask
    task rd(input [7:0] a, output [31:0] v);
        @(posedge core_clk);
        {regAddr, regRdEn} <= {a, 1'b1};
        @(posedge core_clk);
        regRdEn <= 1'b0;
        #1 v = regRdData;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task summarize;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Waits four periods so the load reports a whole period of the new setting.
    task settle(input integer per);
        repeat (4 * per + 8) @(posedge core_clk);
    endtask
    task wave(input [1:0] c, input integer t, m, md, pl, p);
        ch = c;
        wr(ca(c) + 8'h04, {m[15:0], t[15:0]});
        wr(ca(c), {16'h8000, 1'b0, p[2:0], 3'h0, md[0], 3'h0, pl[0], 4'h1});
        settle(ePer(t, md, p));
        chk(lastPeriod, ePer(t, md, p));
        chk(lastHigh, eHigh(t, m, md, pl, p));
        wr(ca(c), 32'h0000_0000);
        repeat (3) @(posedge core_clk);
        chk(pwmOut, 3'h0);
    endtask
    initial
    begin
        repeat (100000) @(posedge core_clk);
        failures++;
        summarize;
    end
    initial
    begin
        {rst_n, regWrEn, regRdEn, regAddr, regWrData, ch} = 0;
        failures = 0;
        n_compared = 0;
        d = $urandom(56);
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        for (i = 0; i < 7; i++)
        begin
            rd(i == 6 ? `PWMC_STATUS : ca(i / 2) + 4 * (i % 2), r);
            chk(r, 32'h0000_0000);
        end
        for (i = 0; i < 6; i++)
        begin
            d = $urandom;
            wr(ca(i % 3) + 8'h04, d);
            rd(ca(i % 3) + 8'h04, r);
            chk(r, d);
            d = $urandom & 32'h7FFE_FFFE;
            wr(ca(i % 3), d);
            rd(ca(i % 3), r);
            chk(r, d & 32'h0000_7110);
        end
        wr(8'h30, $urandom);
        rd(8'h30, r);
        chk(r, 32'h0000_0000);
        for (i = 0; i < 16; i++)
        begin
            t = 2 + $urandom % 4;
            wave(i % 3, t, 1 + $urandom % t, i / 8, $urandom % 2, i % 8);
        end
        wave(2, 3, 3, 0, 0, 0);
        wave(0, 3, 3, 1, 1, 1);
        ch = 1;
        wr(ca(1) + 8'h04, {16'h0002, 16'h0004});
        wr(ca(1), 32'h8000_1001);
        settle(10);
        wr(ca(1) + 8'h04, {16'h0001, 16'h0002});
        settle(10);
        chk(lastPeriod, ePer(4, 0, 1));
        chk(lastHigh, eHigh(4, 2, 0, 0, 1));
        wr(ca(1), 32'h0001_1001);
        settle(10);
        chk(lastPeriod, ePer(2, 0, 1));
        chk(lastHigh, eHigh(2, 1, 0, 0, 1));
        rd(ca(1), r);
        chk(r, 32'h0000_1001);
        // A slow channel keeps its deferred request pending long enough to read it back.
        wr(ca(2) + 8'h04, {16'h0001, 16'h0100});
        wr(ca(2), 32'h8000_7001);
        wr(ca(2), 32'h0001_7001);
        rd(ca(2), r);
        chk(r, 32'h0001_7001);
        rd(`PWMC_STATUS, r);
        chk(r & 32'hFFFF_FFF8, 32'h0000_0400);
        wr(ca(2), 32'h0000_0000);
        rd(`PWMC_STATUS, r);
        chk(r & 32'hFFFF_FFFD, 32'h0000_0000);
        summarize;
    end
endmodule // testbench
